// *** logic/bit_op_decode.sv ***
/*
 * Instruction field decoder for the single-bit operation unit.
 * Purely combinational; assumes the instruction word is stable in the
 * cycle it is offered.
 */
`default_nettype none

module bit_op_decode (
  input wire logic [15:0] instr,
  output logic is_bit_op,
  output logic [1:0] grp,
  output logic [1:0] variant,
  output logic [3:0] bit_sel,
  output logic [2:0] reg_sel
);

  // Bit number field holds the index in octal followed by a zero digit
  always_comb
  begin
    is_bit_op = instr[bit_op_pkg::OPC_HI:bit_op_pkg::OPC_LO] == bit_op_pkg::OPCODE_BIT_OP;
    grp = instr[bit_op_pkg::FUNC_HI:bit_op_pkg::FUNC_HI-1];
    variant = instr[bit_op_pkg::FUNC_LO+1:bit_op_pkg::FUNC_LO];
    bit_sel = instr[bit_op_pkg::BITNO_HI:bit_op_pkg::BITNO_LO];
    reg_sel = instr[bit_op_pkg::REG_HI:bit_op_pkg::REG_LO];
  end

endmodule

`default_nettype wire

// *** logic/bit_op_pkg.sv ***
/*
 * Constants for the single-bit operation execution unit: instruction
 * field layout, sub-operation codes, status flag selects, reset values.
 * Assumes a 16-bit instruction word and seven 16-bit general registers.
 */
`default_nettype none

package bit_op_pkg;

  localparam int WORD_W = 16;

  // Instruction layout: [15:11] opcode, [10:7] function, [6:3] bit no, [2:0] reg
  localparam logic [4:0] OPCODE_BIT_OP = 5'h1f;
  localparam int OPC_HI = 15;
  localparam int OPC_LO = 11;
  localparam int FUNC_HI = 10;
  localparam int FUNC_LO = 7;
  localparam int BITNO_HI = 6;
  localparam int BITNO_LO = 3;
  localparam int REG_HI = 2;
  localparam int REG_LO = 0;

  // Function field: upper two bits pick the group, lower two the variant
  localparam logic [1:0] GRP_SKIP = 2'h0;
  localparam logic [1:0] GRP_WRITE = 2'h1;
  localparam logic [1:0] GRP_STLD = 2'h2;
  localparam logic [1:0] GRP_LOGIC = 2'h3;

  localparam logic [1:0] VAR_ZERO = 2'h0;
  localparam logic [1:0] VAR_ONE = 2'h1;
  localparam logic [1:0] VAR_INV = 2'h2;
  localparam logic [1:0] VAR_ACCUM = 2'h3;

  // Store/load group variants
  localparam logic [1:0] VAR_STORE_CLR = 2'h0;
  localparam logic [1:0] VAR_STORE_INV_SET = 2'h1;
  localparam logic [1:0] VAR_LOAD = 2'h2;
  localparam logic [1:0] VAR_LOAD_INV = 2'h3;

  // Logic group variants
  localparam logic [1:0] VAR_AND_INV = 2'h0;
  localparam logic [1:0] VAR_OR_INV = 2'h1;
  localparam logic [1:0] VAR_AND = 2'h2;
  localparam logic [1:0] VAR_OR = 2'h3;

  // Status flip-flops addressed by bit number when register select is zero
  localparam int NUM_STATUS = 6;
  localparam logic [3:0] ST_CARRY = 4'h0;
  localparam logic [3:0] ST_STATIC_OVF = 4'h1;
  localparam logic [3:0] ST_FLOAT_OVF = 4'h2;
  localparam logic [3:0] ST_ACCUM_FLAG = 4'h3;
  localparam logic [3:0] ST_DYN_OVF = 4'h4;
  localparam logic [3:0] ST_SHIFT_LINK = 4'h5;

  // Status word bit positions
  localparam int SW_CARRY = 0;
  localparam int SW_STATIC_OVF = 1;
  localparam int SW_FLOAT_OVF = 2;
  localparam int SW_ACCUM_FLAG = 3;
  localparam int SW_DYN_OVF = 4;
  localparam int SW_SHIFT_LINK = 5;

  localparam logic RST_FLAG = 1'b0;
  localparam logic [WORD_W-1:0] RST_WORD = 16'h0000;
  localparam int EXEC_CYCLES = 1;

endpackage

`default_nettype wire

// *** logic/single_bit_operation_unit.sv ***
/*
 * Single-bit operation execution unit: tests, writes and combines one
 * bit of a general register or a status flip-flop with a one-bit
 * accumulator flag, and requests a skip of the next instruction.
 * Assumes the sequencer offers one instruction per exec_valid pulse,
 * applies reg_wr_* in the same edge, and reads skip in that cycle.
 */
`default_nettype none

// How it works
// - Nonzero register select operates on one bit of that general register.
// - Register select zero makes bit number pick a status flip-flop instead.
// - Bit field zero is the rightmost bit; 170 octal the sign bit.
// - Bit field is the octal index followed by a zero digit.
// - A one-bit accumulator flag keeps results between instructions.
// - Function field decodes into sixteen sub-operations in four groups.
// - Skip tests: bit zero, bit one, inverted equals flag, equals flag.
// - Writes: clear, set, invert, or copy accumulator flag into the bit.
// - Stores write flag or its inverse, then clear or set the flag.
// - Loads copy bit or its inverse into the flag, bit untouched.
// - Logic ops AND or OR flag with bit or inverted bit.
// - Skip tests on carry or overflow indicators clear that indicator.
// - Instruction recognised by opcode 174000 octal, three fields.
// - Accumulator flag appears in the status word beside dynamic overflow.

module single_bit_operation_unit (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic exec_valid,
  input wire logic [15:0] instr,
  input wire logic [15:0] pc_in,
  input wire logic [15:0] reg_rd_data,
  input wire logic status_wr,
  input wire logic [15:0] status_wr_data,
  input wire logic carry_set,
  input wire logic static_ovf_set,
  input wire logic float_ovf_set,
  input wire logic dyn_ovf_set,
  output logic [2:0] reg_rd_sel,
  output logic reg_wr_en,
  output logic [2:0] reg_wr_sel,
  output logic [15:0] reg_wr_data,
  output logic skip,
  output logic [15:0] pc_next,
  output logic [15:0] status_word,
  output logic accum_flag
);

  // ******************************
  // Decode
  // ******************************
  logic is_bit_op;
  logic [1:0] grp;
  logic [1:0] variant;
  logic [3:0] bit_sel;
  logic [2:0] reg_sel;

  bit_op_decode u_decode (
    .instr(instr),
    .is_bit_op(is_bit_op),
    .grp(grp),
    .variant(variant),
    .bit_sel(bit_sel),
    .reg_sel(reg_sel)
  );

  logic go;
  logic on_status;
  assign go = exec_valid && is_bit_op;
  assign on_status = reg_sel == 3'h0;
  assign reg_rd_sel = reg_sel;

  // ******************************
  // State
  // ******************************
  logic accum_flag_ff;
  logic carry_ff;
  logic static_ovf_ff;
  logic float_ovf_ff;
  logic dyn_ovf_ff;
  logic shift_link_ff;
  logic [5:0] stat_vec;

  assign stat_vec = {shift_link_ff, dyn_ovf_ff, accum_flag_ff,
                     float_ovf_ff, static_ovf_ff, carry_ff};

  function automatic logic pick_status(input logic [5:0] v, input logic [3:0] sel);
    pick_status = (sel < 4'(bit_op_pkg::NUM_STATUS)) ? v[sel[2:0]] : 1'b0;
  endfunction

  // ******************************
  // Operand and results
  // ******************************
  logic operand;
  logic new_bit;
  logic bit_wr;
  logic nxt_flag;
  logic flag_wr;
  logic cond;

  always_comb
  begin
    if (on_status)
      operand = pick_status(stat_vec, bit_sel);
    else
      operand = reg_rd_data[bit_sel];
  end

  always_comb
  begin
    new_bit = operand;
    bit_wr = 1'b0;
    nxt_flag = accum_flag_ff;
    flag_wr = 1'b0;
    cond = 1'b0;
    case (grp)
      bit_op_pkg::GRP_SKIP:
      begin
        case (variant)
          bit_op_pkg::VAR_ZERO: cond = !operand;
          bit_op_pkg::VAR_ONE: cond = operand;
          bit_op_pkg::VAR_INV: cond = (!operand) == accum_flag_ff;
          default: cond = operand == accum_flag_ff;
        endcase
      end
      bit_op_pkg::GRP_WRITE:
      begin
        bit_wr = 1'b1;
        case (variant)
          bit_op_pkg::VAR_ZERO: new_bit = 1'b0;
          bit_op_pkg::VAR_ONE: new_bit = 1'b1;
          bit_op_pkg::VAR_INV: new_bit = !operand;
          default: new_bit = accum_flag_ff;
        endcase
      end
      bit_op_pkg::GRP_STLD:
      begin
        flag_wr = 1'b1;
        case (variant)
          bit_op_pkg::VAR_STORE_CLR:
          begin
            bit_wr = 1'b1;
            new_bit = accum_flag_ff;
            nxt_flag = 1'b0;
          end
          bit_op_pkg::VAR_STORE_INV_SET:
          begin
            bit_wr = 1'b1;
            new_bit = !accum_flag_ff;
            nxt_flag = 1'b1;
          end
          bit_op_pkg::VAR_LOAD: nxt_flag = operand;
          default: nxt_flag = !operand;
        endcase
      end
      default:
      begin
        flag_wr = 1'b1;
        case (variant)
          bit_op_pkg::VAR_AND_INV: nxt_flag = accum_flag_ff & !operand;
          bit_op_pkg::VAR_OR_INV: nxt_flag = accum_flag_ff | !operand;
          bit_op_pkg::VAR_AND: nxt_flag = accum_flag_ff & operand;
          default: nxt_flag = accum_flag_ff | operand;
        endcase
      end
    endcase
  end

  // ******************************
  // Register write-back and sequencing
  // ******************************
  // Write-back is combinational so the register file updates on this edge
  always_comb
  begin
    reg_wr_en = go && bit_wr && !on_status;
    reg_wr_sel = reg_sel;
    reg_wr_data = reg_rd_data;
    reg_wr_data[bit_sel] = new_bit;
  end

  // Skip is a handshake output to the sequencer
  assign skip = go && (grp == bit_op_pkg::GRP_SKIP) && cond;
  assign pc_next = skip ? pc_in + 16'h0002 : pc_in + 16'h0001;

  // ******************************
  // Status flip-flops
  // ******************************
  logic st_hit;
  logic test_clear;
  assign st_hit = go && on_status;
  // Only carry and overflow indicators are reset by a test
  assign test_clear = st_hit && (grp == bit_op_pkg::GRP_SKIP);

  function automatic logic upd(input logic cur, input logic [3:0] idx, input logic [3:0] sel,
                               input logic hit, input logic wr, input logic nb,
                               input logic clr, input logic ev);
    logic r;
    r = cur;
    if (hit && sel == idx && wr)
      r = nb;
    if (clr && sel == idx)
      r = 1'b0;
    // Hardware set wins over an instruction's clear in the same cycle
    if (ev)
      r = 1'b1;
    upd = r;
  endfunction

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      carry_ff <= bit_op_pkg::RST_FLAG;
      static_ovf_ff <= bit_op_pkg::RST_FLAG;
      float_ovf_ff <= bit_op_pkg::RST_FLAG;
      dyn_ovf_ff <= bit_op_pkg::RST_FLAG;
      shift_link_ff <= bit_op_pkg::RST_FLAG;
    end
    else if (status_wr)
    begin
      carry_ff <= status_wr_data[bit_op_pkg::SW_CARRY];
      static_ovf_ff <= status_wr_data[bit_op_pkg::SW_STATIC_OVF];
      float_ovf_ff <= status_wr_data[bit_op_pkg::SW_FLOAT_OVF];
      dyn_ovf_ff <= status_wr_data[bit_op_pkg::SW_DYN_OVF];
      shift_link_ff <= status_wr_data[bit_op_pkg::SW_SHIFT_LINK];
    end
    else
    begin
      carry_ff <= upd(carry_ff, bit_op_pkg::ST_CARRY, bit_sel, st_hit, bit_wr, new_bit,
                      test_clear, carry_set);
      static_ovf_ff <= upd(static_ovf_ff, bit_op_pkg::ST_STATIC_OVF, bit_sel, st_hit,
                           bit_wr, new_bit, test_clear, static_ovf_set);
      float_ovf_ff <= upd(float_ovf_ff, bit_op_pkg::ST_FLOAT_OVF, bit_sel, st_hit,
                          bit_wr, new_bit, test_clear, float_ovf_set);
      dyn_ovf_ff <= upd(dyn_ovf_ff, bit_op_pkg::ST_DYN_OVF, bit_sel, st_hit, bit_wr,
                        new_bit, test_clear, dyn_ovf_set);
      shift_link_ff <= upd(shift_link_ff, bit_op_pkg::ST_SHIFT_LINK, bit_sel, st_hit,
                           bit_wr, new_bit, 1'b0, 1'b0);
    end
  end

  // Accumulator flag; as a status operand a write-group bit write lands here too, but a store's own flag update wins
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      accum_flag_ff <= bit_op_pkg::RST_FLAG;
    else if (status_wr)
      accum_flag_ff <= status_wr_data[bit_op_pkg::SW_ACCUM_FLAG];
    else if (go && flag_wr)
      accum_flag_ff <= nxt_flag;
    else if (st_hit && bit_wr && bit_sel == bit_op_pkg::ST_ACCUM_FLAG)
      accum_flag_ff <= new_bit;
  end

  always_comb
  begin
    status_word = bit_op_pkg::RST_WORD;
    status_word[5:0] = stat_vec;
  end
  assign accum_flag = accum_flag_ff;

  // ******************************
  // Checks
  // ******************************
  sequence s_skip_on_carry;
    go && on_status && grp == bit_op_pkg::GRP_SKIP && bit_sel == bit_op_pkg::ST_CARRY;
  endsequence

  property p_carry_cleared;
    @(posedge core_clk) disable iff (rst)
      (s_skip_on_carry and (!carry_set && !status_wr)) |=> !carry_ff;
  endproperty
  a_carry_cleared: assert property (p_carry_cleared) else $error("carry not cleared");

  property p_skip_pc;
    @(posedge core_clk) disable iff (rst)
      go && grp == bit_op_pkg::GRP_SKIP && variant == bit_op_pkg::VAR_ONE && operand
      |-> skip && pc_next == pc_in + 16'h0002;
  endproperty
  a_skip_pc: assert property (p_skip_pc) else $error("skip pc wrong");

  property p_noskip_pc;
    @(posedge core_clk) disable iff (rst) !go |-> !skip && pc_next == pc_in + 16'h0001;
  endproperty
  a_noskip_pc: assert property (p_noskip_pc) else $error("pc step wrong");

  property p_store_clear;
    @(posedge core_clk) disable iff (rst)
      go && grp == bit_op_pkg::GRP_STLD && variant == bit_op_pkg::VAR_STORE_CLR && !status_wr
      |=> !accum_flag;
  endproperty
  a_store_clear: assert property (p_store_clear) else $error("store did not clear");

  property p_store_set;
    @(posedge core_clk) disable iff (rst)
      go && grp == bit_op_pkg::GRP_STLD && variant == bit_op_pkg::VAR_STORE_INV_SET
      && !status_wr |=> accum_flag;
  endproperty
  a_store_set: assert property (p_store_set) else $error("store did not set");

  property p_load;
    @(posedge core_clk) disable iff (rst)
      go && grp == bit_op_pkg::GRP_STLD && variant == bit_op_pkg::VAR_LOAD && !status_wr
      |=> accum_flag == $past(operand);
  endproperty
  a_load: assert property (p_load) else $error("load wrong");

  property p_flag_hold;
    @(posedge core_clk) disable iff (rst) !exec_valid && !status_wr |=> $stable(accum_flag);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag changed idle");

  property p_skip_zero;
    @(posedge core_clk) disable iff (rst)
      go && grp == bit_op_pkg::GRP_SKIP && variant == bit_op_pkg::VAR_ZERO |-> skip == !operand;
  endproperty
  a_skip_zero: assert property (p_skip_zero) else $error("skip zero wrong");

  property p_no_reg_write;
    @(posedge core_clk) disable iff (rst)
      reg_wr_en |-> !on_status && bit_wr
      && (reg_wr_data ^ reg_rd_data) == (16'(new_bit ^ operand) << bit_sel);
  endproperty
  a_no_reg_write: assert property (p_no_reg_write) else $error("bad reg write");

endmodule

`default_nettype wire

// *** sim/test_single_bit_operation_unit.sv ***
/*
 * Self-checking bench for the single-bit operation unit.
 * Assumes the design package and unit from logic/; drives at falling edges.
 */
`default_nettype none

module test_single_bit_operation_unit;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic skp;
    logic [15:0] pcn;
    logic wen;
    logic [2:0] wsel;
    logic [15:0] wdat;
    logic [5:0] st;
  } note_s;

  logic core_clk, rst, exec_valid, status_wr, skip, accum_flag, reg_wr_en;
  logic carry_set, static_ovf_set, float_ovf_set, dyn_ovf_set;
  logic [15:0] instr, pc_in, reg_rd_data, status_wr_data, reg_wr_data, pc_next, status_word;
  logic [2:0] reg_rd_sel, reg_wr_sel;
  logic [5:0] model_st;
  int n_mismatch, n_tests;
  integer seed;
  note_s q[$];
  note_s pend;
  logic have_pend;

  single_bit_operation_unit i_dut (.core_clk(core_clk), .rst(rst), .exec_valid(exec_valid),
    .instr(instr), .pc_in(pc_in), .reg_rd_data(reg_rd_data), .status_wr(status_wr),
    .status_wr_data(status_wr_data), .carry_set(carry_set),
    .static_ovf_set(static_ovf_set), .float_ovf_set(float_ovf_set),
    .dyn_ovf_set(dyn_ovf_set), .reg_rd_sel(reg_rd_sel), .reg_wr_en(reg_wr_en),
    .reg_wr_sel(reg_wr_sel), .reg_wr_data(reg_wr_data), .skip(skip), .pc_next(pc_next),
    .status_word(status_word), .accum_flag(accum_flag));

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
      n_mismatch++;
    end
  endtask

  task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask

  task automatic close_out();
    $display("compares %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ****************************************
  // Stimulus and reference model
  // ****************************************
  task automatic load_st(input logic [5:0] v);
    @(negedge core_clk);
    {exec_valid, status_wr, carry_set, static_ovf_set, float_ovf_set, dyn_ovf_set} = 6'h10;
    status_wr_data = {10'($random(seed)), v};
    model_st = v;
  endtask

  task automatic run(input logic [15:0] ins, input logic [15:0] rd, input logic [3:0] sets);
    note_s n;
    logic b, k, nb, nk, hit, wr, is_op;
    logic [1:0] g, v;
    logic [3:0] bn;
    logic [2:0] rs;
    @(negedge core_clk);
    {exec_valid, status_wr, instr, reg_rd_data} = {2'h2, ins, rd};
    pc_in = 16'($random(seed));
    {dyn_ovf_set, float_ovf_set, static_ovf_set, carry_set} = sets;
    is_op = ins[15:11] == bit_op_pkg::OPCODE_BIT_OP;
    {g, v, bn, rs} = ins[10:0];
    hit = rs == 3'h0 && bn < 4'h6;
    b = (rs != 3'h0) ? rd[bn] : (hit && model_st[bn[2:0]]);
    k = model_st[3];
    n = '0;
    n.skp = is_op && g == 2'h0 && (v[1] ? ((b ^ !v[0]) == k) : (b == v[0]));
    wr = is_op && (g == 2'h1 || (g == 2'h2 && !v[1]));
    nb = (g == 2'h2) ? (k ^ v[0]) : (v == 2'h0) ? 1'b0 : (v == 2'h1) ? 1'b1 : (v == 2'h2) ? !b : k;
    nk = (g == 2'h2) ? (v[1] ? (b ^ v[0]) : v[0]) : k;
    if (g == 2'h3)
      nk = v[0] ? (k | (b ^ !v[1])) : (k & (b ^ !v[1]));
    if (is_op)
      model_st[3] = nk;
    if (wr && hit)
      model_st[bn[2:0]] = nb;
    if (is_op && g == 2'h0 && hit && bn != 4'h3 && bn != 4'h5)
      model_st[bn[2:0]] = 1'b0;
    model_st = model_st | {1'b0, sets[3], 1'b0, sets[2:0]};
    n.wen = wr && rs != 3'h0;
    n.wsel = rs;
    n.wdat = rd;
    n.wdat[bn] = nb;
    n.pcn = pc_in + (n.skp ? 16'h0002 : 16'h0001);
    n.st = model_st;
    q.push_back(n);
  endtask

  // ****************************************
  // Output watcher
  // ****************************************
  initial
  begin
    have_pend = 1'b0;
    forever
    begin
      @(negedge core_clk);
      #20;
      if (have_pend)
      begin
        chk_word("status_word", {10'h000, pend.st}, status_word);
        chk_bit("accum_flag", pend.st[3], accum_flag);
        have_pend = 1'b0;
      end
      if (exec_valid === 1'b1 && q.size() > 0)
      begin
        pend = q.pop_front();
        have_pend = 1'b1;
        chk_bit("skip", pend.skp, skip);
        chk_word("pc_next", pend.pcn, pc_next);
        chk_word("reg_rd_sel", {13'h0, instr[2:0]}, {13'h0, reg_rd_sel});
        chk_bit("reg_wr_en", pend.wen, reg_wr_en);
        if (pend.wen)
        begin
          chk_word("reg_wr_sel", {13'h0, pend.wsel}, {13'h0, reg_wr_sel});
          chk_word("reg_wr_data", pend.wdat, reg_wr_data);
        end
      end
    end
  end

  initial
  begin
    repeat (20000) @(posedge core_clk);
    $display("timeout");
    n_mismatch++;
    close_out();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    logic [15:0] rd, ins;
    logic [3:0] bn;
    logic [2:0] rs;
    {exec_valid, status_wr, carry_set, static_ovf_set, float_ovf_set, dyn_ovf_set} = 6'h0;
    {instr, pc_in, reg_rd_data, status_wr_data} = 64'h0;
    {n_tests, n_mismatch, seed, model_st, rst} = {32'h0, 32'h0, 32'd68835, 6'h0, 1'b1};
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    chk_word("status_word", 16'h0000, status_word);
    run({5'h1f, 4'h5, 4'h6, 3'h3}, 16'h0000, 4'h0);
    run({5'h1f, 4'h6, 4'hf, 3'h7}, 16'h8001, 4'h0);
    $display("test directed bits done");
    for (int f = 0; f < 64; f++)
    begin
      load_st({2'h0, f[1], 3'h0});
      rd = 16'($random(seed));
      bn = 4'($random(seed));
      rs = 3'h1 + 3'({$random(seed)} % 7);
      rd[bn] = f[0];
      run({5'h1f, f[5:2], bn, rs}, rd, 4'h0);
    end
    $display("test function table done");
    for (int i = 0; i < 32; i++)
    begin
      load_st(6'h3f);
      run({5'h1f, 2'h0, i[1:0], 1'b0, i[4:2], 3'h0}, 16'h0, 4'h0);
    end
    load_st(6'h3f);
    run({5'h1f, 4'h1, 4'h0, 3'h0}, 16'h0, 4'h1);
    $display("test status flags done");
    repeat (400)
    begin
      ins = 16'($random(seed));
      if (ins[14:13] != 2'h0)
        ins[15:11] = 5'h1f;
      if (ins[2:0] == 3'h0 && ins[6:3] == 4'h3 && ins[10:9] == 2'h2)
        ins[6:3] = 4'h0;
      if (({$random(seed)} % 8) == 0)
        load_st(6'($random(seed)));
      if (({$random(seed)} % 8) == 1)
      begin
        @(negedge core_clk);
        {exec_valid, status_wr, carry_set, static_ovf_set, float_ovf_set, dyn_ovf_set} = 6'h0;
        instr = {5'h1f, 11'($random(seed))};
      end
      run(ins, 16'($random(seed)), (ins[10:9] == 2'h0) ? 4'($random(seed) & $random(seed)) : 4'h0);
    end
    @(negedge core_clk);
    exec_valid = 1'b0;
    repeat (3) @(negedge core_clk);
    chk_word("notes_left", 16'h0000, 16'(q.size()));
    $display("test random stream done");
    close_out();
  end
endmodule

`default_nettype wire
